/* rtl/rtc_defs.svh */
// Purpose: offsets, field positions, reset values and band constants
// Assumes: 8-bit registers on the parallel register port
// Notes:   definitions only
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// ==========================================
// register offsets
`define RTC_OFS_MODE   8'h0A
`define RTC_OFS_FREQ_A 8'h0B
`define RTC_OFS_FREQ_B 8'h0C
`define RTC_OFS_GATE   8'h0F
`define RTC_OFS_THRESH 8'h11
`define RTC_OFS_DEV    8'h12
`define RTC_OFS_AMP    8'h13
// ==========================================
// field positions
`define RTC_BIT_DIR    5
`define RTC_BIT_MOD    4
`define RTC_BIT_GATE   3
`define RTC_BIT_AMP_EN 1
`define RTC_DEV_HI     7
`define RTC_DEV_LO     2
// ==========================================
// reset values
`define RTC_RST_MODE   8'h00
`define RTC_RST_FREQ   8'h00
`define RTC_RST_GATE   8'h00
`define RTC_RST_THRESH 8'h00
`define RTC_RST_DEV    8'h00
`define RTC_RST_AMP    8'hFC
// ==========================================
// band codes and dividers, step of 10 kHz in Hz
`define RTC_BAND_315   2'h0
`define RTC_BAND_434   2'h1
`define RTC_BAND_868   2'h2
`define RTC_BAND_915   2'h3
`define RTC_DIV_315    20'h00006
`define RTC_DIV_434    20'h00004
`define RTC_DIV_HIGH   20'h00002
`define RTC_FD_HZ      20'h02710
`endif

/* rtl/rtc_pkg.sv */
// Purpose: shared types of the transmit control block
// Assumes: nothing
// Notes:   numbers live in rtc_defs.svh
package rtc_pkg;
    typedef struct packed {
        logic       dir;
        logic       mod_ask;
        logic [1:0] band;
    } rtc_mode_t;

    typedef struct packed {
        logic [3:0] fine;
        logic [1:0] coarse;
        logic       en;
    } rtc_amp_t;

    typedef enum logic [1:0] {
        RTC_GATE_HOLD = 2'h0,
        RTC_GATE_PASS = 2'h1
    } rtc_gate_t;
endpackage

/* rtl/rtc_sync2.sv */
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: inputs are levels
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
module rtc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* rtl/rtc_track.sv */
// Purpose: comparator reference tracker with fast tracking
// Assumes: sample and threshold share one code scale
// Notes:   coefficients are shifts, fast is the combined one
`timescale 1ns/1ns
module rtc_track #(
    parameter int W          = 8,
    parameter int NORM_SHIFT = 4,
    parameter int FAST_SHIFT = 2
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] sample,
    input  wire logic [W-1:0] threshold,
    output logic      [W-1:0] vref_reg,
    output logic              fast_reg
);
    logic signed [W+1:0] delta;
    logic signed [W+1:0] neg;
    logic signed [W+1:0] step;
    logic signed [W+1:0] sum;
    logic        [W:0]   mag;
    logic                fast;

    assign delta = $signed({2'b00, sample}) - $signed({2'b00, vref_reg});
    assign neg   = -delta;
    assign mag   = delta[W+1] ? neg[W:0] : delta[W:0];
    assign fast  = mag >= {1'b0, threshold};                          // see R2
    // arithmetic shift may leave a residue of up to 15 codes (NORM_SHIFT 4) below the sample; accepted
    assign step  = fast ? (delta >>> FAST_SHIFT) : (delta >>> NORM_SHIFT); // see R2
    assign sum   = $signed({2'b00, vref_reg}) + step;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vref_reg <= '0;
            fast_reg <= 1'b0;
        end else begin
            vref_reg <= sum[W-1:0];
            fast_reg <= fast;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_fast_thr;
        (mag >= {1'b0, threshold}) |=> fast_reg;
    endproperty
    a_fast_thr: assert property (p_fast_thr) else $error("fast track missed"); // see R2
endmodule

/* rtl/rtc_txctl.sv */
// Purpose: transmit path control, data pin gating, amplifier enable
// Assumes: register port is fed by the serial framing logic
// Notes:   detection, demod and low_power come from same-clock logic
// Contract
// R1 - fast tracking threshold is an 8-bit field, code = kHz times 1.53
// R2 - reference tracks with faster coefficient while difference reaches threshold
// R3 - receive, gating off: drive demodulated data on the pin always
// R4 - receive, gating on: pin low until first detection rise, then data
// R5 - once gated output started it stays until low power entry
// R6 - gating on without detection in use keeps pin low
// R7 - direction 1 selects transmit, pin becomes input driven by host
// R8 - modulation select 0 is FSK, 1 is amplitude keying
// R9 - FSK modulates synthesizer from pin, code 0 means plain carrier
// R10 - deviation is 10 kHz times n over band divider 6, 4 or 2
// R11 - amplitude keying: amplifier off for data 0, on for 1
// R12 - amplifier enabled only with transmit, enable bit and lock flag
// R13 - lock flag sets on first lock rise and holds if lock drops
// R14 - lock flag clears on low power, to-receive, modulation, frequency changes
// R15 - host never changes band bits alone while transmitting
// R16 - lock flag acts in transmit only and is never readable
// R17 - coarse 2-bit and fine 4-bit level fields, both reset to maximum
// R18 - receive-only systems never select transmit
// R19 - reset clears gated-output start and lock flag
`timescale 1ns/1ns
`include "rtc_defs.svh"
module rtc_txctl #(
    parameter int VW = 8
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          reg_wr_en,
    input  wire logic          reg_rd_en,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wr_data,
    output logic      [7:0]    reg_rd_data,
    input  wire logic          low_power,
    input  wire logic          detection_output,
    input  wire logic          detect_enable,
    input  wire logic          demod_data,
    input  wire logic [VW-1:0] cmp_sample,
    input  wire logic          data_pin_in,
    output logic               data_pin_out,
    output logic               data_pin_oe,
    input  wire logic          synth_lock_detect,
    output logic               amplifier_enable,
    output logic               amp_drive,
    output logic      [1:0]    amp_coarse,
    output logic      [3:0]    amp_fine,
    output logic               fsk_active,
    output logic               fsk_shift_up,
    output logic      [19:0]   deviation_hz,
    output logic               tx_ask,
    output logic               fast_track,
    output logic      [VW-1:0] comparator_ref
);
    import rtc_pkg::*;

    // ==========================================
    // registers
    logic [7:0]       mode_reg;
    logic [7:0]       freq_a_reg;
    logic [7:0]       freq_b_reg;
    logic [7:0]       gate_reg;
    logic [7:0]       thresh_reg;
    logic [7:0]       dev_reg;
    logic [7:0]       amp_reg;
    rtc_mode_t        mode;
    rtc_amp_t         amp_cfg;
    logic [5:0]       dev_code;
    logic             wr_mode;
    logic             wr_fa;
    logic             wr_fb;
    logic             wr_dev;
    logic             wr_amp;

    assign wr_mode  = reg_wr_en && reg_addr == `RTC_OFS_MODE;
    assign wr_fa    = reg_wr_en && reg_addr == `RTC_OFS_FREQ_A;
    assign wr_fb    = reg_wr_en && reg_addr == `RTC_OFS_FREQ_B;
    assign wr_dev   = reg_wr_en && reg_addr == `RTC_OFS_DEV;
    assign wr_amp   = reg_wr_en && reg_addr == `RTC_OFS_AMP;
    assign mode     = '{dir: mode_reg[`RTC_BIT_DIR], mod_ask: mode_reg[`RTC_BIT_MOD],
                        band: mode_reg[1:0]};
    assign amp_cfg  = '{fine: amp_reg[7:4], coarse: amp_reg[3:2],
                        en: amp_reg[`RTC_BIT_AMP_EN]};
    assign dev_code = dev_reg[`RTC_DEV_HI:`RTC_DEV_LO];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_reg   <= `RTC_RST_MODE;
            freq_a_reg <= `RTC_RST_FREQ;
            freq_b_reg <= `RTC_RST_FREQ;
            gate_reg   <= `RTC_RST_GATE;
            thresh_reg <= `RTC_RST_THRESH;
            dev_reg    <= `RTC_RST_DEV;
            amp_reg    <= `RTC_RST_AMP;                              // see R17
        end else if (reg_wr_en) begin
            case (reg_addr)
                `RTC_OFS_MODE:   mode_reg   <= reg_wr_data;
                `RTC_OFS_FREQ_A: freq_a_reg <= reg_wr_data;
                `RTC_OFS_FREQ_B: freq_b_reg <= reg_wr_data;
                `RTC_OFS_GATE:   gate_reg   <= reg_wr_data;
                `RTC_OFS_THRESH: thresh_reg <= reg_wr_data;            // see R1
                `RTC_OFS_DEV:    dev_reg    <= reg_wr_data;
                `RTC_OFS_AMP:    amp_reg    <= reg_wr_data;            // see R17
                default: ;
            endcase
        end
    end

    // lock flag deliberately absent from the read map
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)                                           // see R16
                `RTC_OFS_MODE:   reg_rd_data <= mode_reg;
                `RTC_OFS_FREQ_A: reg_rd_data <= freq_a_reg;
                `RTC_OFS_FREQ_B: reg_rd_data <= freq_b_reg;
                `RTC_OFS_GATE:   reg_rd_data <= gate_reg;
                `RTC_OFS_THRESH: reg_rd_data <= thresh_reg;
                `RTC_OFS_DEV:    reg_rd_data <= dev_reg;
                `RTC_OFS_AMP:    reg_rd_data <= amp_reg;
                default:         reg_rd_data <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // pin inputs and tracker
    logic tx_data_s;
    logic lock_s;
    logic lock_d_reg;
    logic det_d_reg;

    rtc_sync2 #(.W(2)) u_sync (
        .clock (clock),
        .rst   (rst),
        .d     ({data_pin_in, synth_lock_detect}),
        .q     ({tx_data_s, lock_s})
    );

    rtc_track #(.W(VW)) u_track (
        .clock     (clock),
        .rst       (rst),
        .sample    (cmp_sample),
        .threshold (thresh_reg[VW-1:0]),
        .vref_reg  (comparator_ref),
        .fast_reg  (fast_track)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_d_reg <= 1'b0;
            det_d_reg  <= 1'b0;
        end else begin
            lock_d_reg <= lock_s;
            det_d_reg  <= detection_output;
        end
    end

    // ==========================================
    // latched lock flag
    logic latched_lock_flag_reg;
    logic lock_set;
    logic lock_clear;

    assign lock_set   = lock_s && !lock_d_reg && mode.dir;              // see R13
    // band-only writes do not release; host must avoid them in transmit
    assign lock_clear = low_power                                      // see R14
        || (wr_mode && mode.dir && !reg_wr_data[`RTC_BIT_DIR])
        || (wr_mode && reg_wr_data[`RTC_BIT_MOD] != mode.mod_ask)
        || (wr_fa && reg_wr_data != freq_a_reg)
        || (wr_fb && reg_wr_data != freq_b_reg)
        || (wr_dev && !mode.mod_ask
            && reg_wr_data[`RTC_DEV_HI:`RTC_DEV_LO] != dev_code);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            latched_lock_flag_reg <= 1'b0;                             // see R19
        end else if (lock_set) begin
            latched_lock_flag_reg <= 1'b1;                             // see R13
        end else if (lock_clear) begin
            latched_lock_flag_reg <= 1'b0;                             // see R14
        end
    end

    // ==========================================
    // data pin gating
    rtc_gate_t gate_state_reg;
    logic      gate_on;
    logic      rx_value;

    assign gate_on = gate_reg[`RTC_BIT_GATE];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gate_state_reg <= RTC_GATE_HOLD;                           // see R19
        end else begin
            case (gate_state_reg)
                RTC_GATE_HOLD: begin
                    if (!low_power && !mode.dir && gate_on && detect_enable
                        && detection_output && !det_d_reg) begin
                        gate_state_reg <= RTC_GATE_PASS;                // see R4
                    end
                end
                RTC_GATE_PASS: begin
                    if (low_power) begin
                        gate_state_reg <= RTC_GATE_HOLD;                // see R5
                    end
                end
                default: gate_state_reg <= RTC_GATE_HOLD;
            endcase
        end
    end

    // without detection in use the state never leaves hold
    assign rx_value = !gate_on ? demod_data                              // see R3
                    : (gate_state_reg == RTC_GATE_PASS) && demod_data;    // see R6
    assign data_pin_oe = !mode.dir;                                      // see R7

    // ==========================================
    // transmit: amplifier and FSK
    logic [19:0] divider;
    logic [19:0] dev_scaled;

    assign amplifier_enable = mode.dir && amp_cfg.en
                              && latched_lock_flag_reg;                // see R12
    assign fsk_active       = mode.dir && !mode.mod_ask && dev_code != 6'h00; // see R9
    assign tx_ask           = mode.dir && mode.mod_ask;               // see R8
    assign amp_coarse       = amp_cfg.coarse;                          // see R17
    assign amp_fine         = amp_cfg.fine;
    assign dev_scaled       = `RTC_FD_HZ * {14'h0000, dev_code};

    always_comb begin
        case (mode.band)
            `RTC_BAND_315: divider = `RTC_DIV_315;                       // see R10
            `RTC_BAND_434: divider = `RTC_DIV_434;
            default:       divider = `RTC_DIV_HIGH;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_pin_out <= 1'b0;
            amp_drive    <= 1'b0;
            fsk_shift_up <= 1'b0;
            deviation_hz <= 20'h00000;
        end else begin
            data_pin_out <= !mode.dir && rx_value;
            amp_drive    <= amplifier_enable
                            && (mode.mod_ask ? tx_data_s : 1'b1);     // see R11
            fsk_shift_up <= fsk_active && tx_data_s;                   // see R9
            deviation_hz <= dev_scaled / divider;                      // see R10
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_rx_plain;
        (!mode.dir && !gate_on) |=> data_pin_out == $past(demod_data);
    endproperty
    a_rx_plain: assert property (p_rx_plain) else $error("plain rx data lost"); // see R3

    property p_hold_low;
        (!mode.dir && gate_on && gate_state_reg == RTC_GATE_HOLD) |=> !data_pin_out;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("pin not low"); // see R4

    property p_pass_keep;
        (gate_state_reg == RTC_GATE_PASS && !low_power) |=> gate_state_reg == RTC_GATE_PASS;
    endproperty
    a_pass_keep: assert property (p_pass_keep) else $error("gating dropped"); // see R5

    property p_no_det;
        (!detect_enable && gate_state_reg == RTC_GATE_HOLD)
            |=> gate_state_reg == RTC_GATE_HOLD;
    endproperty
    a_no_det: assert property (p_no_det) else $error("gating without detection"); // see R6

    property p_tx_input;
        (wr_mode && reg_wr_data[`RTC_BIT_DIR]) |=> !data_pin_oe ##1 !data_pin_out;
    endproperty
    a_tx_input: assert property (p_tx_input) else $error("pin driven in tx"); // see R7

    property p_lock_set;
        lock_set |=> latched_lock_flag_reg;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not latched"); // see R13

    property p_lock_hold;
        (latched_lock_flag_reg && !lock_clear) |=> latched_lock_flag_reg;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock flag lost"); // see R13

    property p_lock_clr;
        (lock_clear && !lock_set) |=> !latched_lock_flag_reg;
    endproperty
    a_lock_clr: assert property (p_lock_clr) else $error("lock flag stuck"); // see R14

    property p_ask_off;
        (tx_ask && !tx_data_s) |=> !amp_drive;
    endproperty
    a_ask_off: assert property (p_ask_off) else $error("amp on for zero"); // see R11

    property p_pa_rx;
        !mode.dir |=> !amp_drive && !amplifier_enable;
    endproperty
    a_pa_rx: assert property (p_pa_rx) else $error("amp on in rx"); // see R12

    property p_dev434;
        (mode.band == `RTC_BAND_434 && dev_code == 6'h0C) |=> deviation_hz == 20'd30000;
    endproperty
    a_dev434: assert property (p_dev434) else $error("deviation wrong"); // see R10

    property p_fsk_dir;
        (fsk_active && tx_data_s) |=> fsk_shift_up;
    endproperty
    a_fsk_dir: assert property (p_fsk_dir) else $error("fsk shift missing"); // see R9

    c_gate_pass: cover property (gate_state_reg == RTC_GATE_HOLD ##1
                                 gate_state_reg == RTC_GATE_PASS);
    c_pa_on:     cover property ($rose(amplifier_enable));
    c_lock_rel:  cover property (latched_lock_flag_reg ##1 !latched_lock_flag_reg);
endmodule

/* dv/rtc_host_model.sv */
// Purpose: host side of the data pin
// Assumes: device enable high means the device owns the pin
// Notes:   the testbench hands in the transmit bit
`timescale 1ns/1ns
module rtc_host_model (
    input  wire logic data_pin_oe,
    input  wire logic data_pin_out,
    input  wire logic tx_bit,
    output logic      data_pin_in
);
    // ==========================================
    // pin level
    // host stays off the wire while the device drives it
    always_comb begin
        data_pin_in = data_pin_oe ? data_pin_out : tx_bit;
    end
endmodule

/* dv/rtc_txctl_tb_top.sv */
// Purpose: self-checking bench of the transmit control block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   expectations queue up, compared at the falling edge
`timescale 1ns/1ns
module rtc_txctl_tb_top;
    import rtc_pkg::*;
    // ==========================================
    // signals
    typedef struct {
        string       name;
        int          sel;
        logic [19:0] exp;
    } rtc_note_t;
    logic        clock, rst, reg_wr_en, reg_rd_en, low_power;
    logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, cmp_sample, comparator_ref;
    logic        detection_output, detect_enable, demod_data, data_pin_in;
    logic        data_pin_out, data_pin_oe, synth_lock_detect, amplifier_enable;
    logic        amp_drive, fsk_active, fsk_shift_up, tx_ask, fast_track, tx_bit, b;
    logic [1:0]  amp_coarse;
    logic [3:0]  amp_fine;
    logic [19:0] deviation_hz;
    logic [31:0] seed;
    logic [7:0]  v;
    rtc_note_t   q[$];
    rtc_note_t   mon_e;
    int          errors, n_tests;
    logic [7:0]  ca[5] = '{8'h12, 8'h0B, 8'h0C, 8'h0A, 8'h12};
    logic [7:0]  cd[5] = '{8'h34, 8'h5A, 8'hA5, 8'h31, 8'h30};
    logic [19:0] ce[5] = '{20'h0, 20'h0, 20'h0, 20'h0, 20'h1};
    logic [19:0] dv[4] = '{20'h19A28, 20'h2673C, 20'h4CE78, 20'h4CE78};

    always #50 clock = ~clock;

    rtc_txctl uut (
        .clock(clock), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .low_power(low_power), .detection_output(detection_output),
        .detect_enable(detect_enable), .demod_data(demod_data), .cmp_sample(cmp_sample),
        .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
        .synth_lock_detect(synth_lock_detect), .amplifier_enable(amplifier_enable),
        .amp_drive(amp_drive), .amp_coarse(amp_coarse), .amp_fine(amp_fine),
        .fsk_active(fsk_active), .fsk_shift_up(fsk_shift_up), .deviation_hz(deviation_hz),
        .tx_ask(tx_ask), .fast_track(fast_track), .comparator_ref(comparator_ref)
    );

    rtc_host_model host (
        .data_pin_oe(data_pin_oe), .data_pin_out(data_pin_out),
        .tx_bit(tx_bit), .data_pin_in(data_pin_in)
    );

    // ==========================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction

    function automatic logic [19:0] pick(input int sel);
        case (sel)
            0: pick = {12'h0, reg_rd_data};
            1: pick = {19'h0, data_pin_out};
            2: pick = {19'h0, data_pin_oe};
            3: pick = {19'h0, amplifier_enable};
            4: pick = {19'h0, amp_drive};
            5: pick = deviation_hz;
            6: pick = {19'h0, fsk_active};
            7: pick = {19'h0, tx_ask};
            8: pick = {18'h0, amp_coarse};
            9: pick = {16'h0, amp_fine};
            10: pick = {19'h0, fsk_shift_up};
            11: pick = {19'h0, fast_track};
            default: pick = {12'h0, comparator_ref};
        endcase
    endfunction

    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic note(input string name, input int sel, input logic [19:0] exp);
        q.push_back('{name, sel, exp});
    endtask

    // comparator sample input keeps moving so the tracker is exercised
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
        seed = xs(seed);
        cmp_sample = seed[15:8];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        step(1);
        reg_wr_en = 1'b0;
        // idle edge so the next call never re-raises the strobe at once
        step(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
        reg_addr = a;
        reg_rd_en = 1'b1;
        step(1);
        reg_rd_en = 1'b0;
        step(1);
        note(name, 0, {12'h0, e});
    endtask

    // lock detect must fall before a fresh rise can be seen
    task automatic lock();
        synth_lock_detect = 1'b0;
        step(3);
        synth_lock_detect = 1'b1;
        step(5);
    endtask

    task automatic rx_follow(input int n, input string name);
        for (int i = 0; i < n; i++) begin
            b = seed[3];
            demod_data = b;
            step(1);
            note(name, 1, {19'h0, b});
        end
    endtask

    task automatic finish_test();
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================
    // monitor
    always @(negedge clock) begin
        while (q.size() > 0) begin
            mon_e = q.pop_front();
            check(mon_e.name, pick(mon_e.sel), mon_e.exp);
        end
    end

    // ==========================================
    // watchdog
    initial begin
        #400000;
        errors++;
        finish_test();
    end

    // ==========================================
    // main sequence
    initial begin
        {clock, reg_wr_en, reg_rd_en, low_power, detection_output} = '0;
        {detect_enable, demod_data, synth_lock_detect, tx_bit, b} = '0;
        {reg_addr, reg_wr_data, cmp_sample, v} = '0;
        errors = 0;
        n_tests = 0;
        seed = 32'hCF04;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        rst = 1'b0;
        note("ref reset", 12, 20'h0);
        step(1);
        rd(8'h13, 8'hFC, "amp reg");
        rd(8'h0A, 8'h00, "mode reg");
        rd(8'h20, 8'h00, "unmapped");
        note("coarse max", 8, 20'h3);
        note("fine max", 9, 20'hF);
        note("oe rx", 2, 20'h1);
        v = seed[7:0];
        wr(8'h11, v);
        rd(8'h11, v, "threshold");
        wr(8'h11, 8'h00);
        note("fast track", 11, 20'h1);
        // receive phase keeps direction at 0
        rx_follow(8, "rx data");
        wr(8'h0F, 8'h08);
        demod_data = 1'b1;
        detection_output = 1'b1;
        step(3);
        note("gate unused", 1, 20'h0);
        detection_output = 1'b0;
        detect_enable = 1'b1;
        step(2);
        note("gate wait", 1, 20'h0);
        detection_output = 1'b1;
        step(2);
        note("gate open", 1, 20'h1);
        detection_output = 1'b0;
        rx_follow(6, "gate held");
        low_power = 1'b1;
        step(1);
        low_power = 1'b0;
        demod_data = 1'b1;
        step(2);
        note("gate closed", 1, 20'h0);
        // frequency moves in transmit go through 0x0B and 0x0C, never band bits alone
        wr(8'h12, 8'h30);
        wr(8'h0A, 8'h21);
        wr(8'h13, 8'h76);
        step(2);
        note("oe tx", 2, 20'h0);
        note("dev 434", 5, 20'h07530);
        note("fsk on", 6, 20'h1);
        note("coarse", 8, 20'h1);
        note("fine", 9, 20'h7);
        note("no lock", 3, 20'h0);
        lock();
        note("amp on", 3, 20'h1);
        synth_lock_detect = 1'b0;
        step(4);
        note("lock held", 3, 20'h1);
        wr(8'h13, 8'h74);
        note("en off", 3, 20'h0);
        wr(8'h13, 8'h76);
        note("en on", 3, 20'h1);
        for (int i = 0; i < 5; i++) begin
            lock();
            wr(ca[i], cd[i]);
            step(1);
            note("lock clear", 3, ce[i]);
        end
        note("ask", 7, 20'h1);
        note("ask not fsk", 6, 20'h0);
        for (int i = 0; i < 6; i++) begin
            b = seed[5];
            tx_bit = b;
            step(5);
            note("ask drive", 4, {19'h0, b});
        end
        low_power = 1'b1;
        step(1);
        low_power = 1'b0;
        step(1);
        note("low power clr", 3, 20'h0);
        lock();
        wr(8'h0A, 8'h01);
        step(1);
        note("to rx clr", 3, 20'h0);
        tx_bit = 1'b1;
        wr(8'h12, 8'hFC);
        for (int i = 0; i < 4; i++) begin
            wr(8'h0A, 8'(i)); // band moves only while in receive
            wr(8'h0A, 8'h20 | 8'(i));
            step(2);
            note("dev band", 5, dv[i]);
            note("fsk shift", 10, {19'h0, tx_bit});
        end
        wr(8'h12, 8'h00);
        step(2);
        note("plain carrier", 6, 20'h0);
        lock();
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(1);
        note("reset lock", 3, 20'h0);
        rd(8'h0A, 8'h00, "mode after rst");
        step(2);
        finish_test();
    end
endmodule
